/* File: verilog/pmcrb_defs.svh */
// Purpose: offsets, field positions, reset values and timing for the control register bank
// Assumes: 8-bit registers on an 8-bit register address
// Notes: definitions only
`ifndef PMCRB_DEFS_SVH
`define PMCRB_DEFS_SVH

`define PMCRB_ADDR_MODE_STATUS 8'h0c
`define PMCRB_ADDR_MAIN_CTRL 8'h10
`define PMCRB_ADDR_LOW_SUPPLY 8'h11
`define PMCRB_ADDR_LONG_PRESS 8'h12
`define PMCRB_ADDR_WDT_CTRL 8'h13
`define PMCRB_ADDR_WDT_PERIOD 8'h14
`define PMCRB_ADDR_WDT_REMAIN 8'h15
`define PMCRB_ADDR_OCP_SW 8'h16
`define PMCRB_ADDR_OCP_LDO 8'h17
`define PMCRB_ADDR_PAD_PULL 8'h18
`define PMCRB_ADDR_DISCH_1 8'h19
`define PMCRB_ADDR_DISCH_2 8'h1a

`define PMCRB_RST_MAIN_CTRL 8'h80
`define PMCRB_RST_LOW_SUPPLY 8'h00
`define PMCRB_RST_WDT_REMAIN 8'h00
`define PMCRB_RST_PAD_PULL 8'h57

`define PMCRB_MAIN_SOFTWARE_SWITCH_OFF_BIT 0
`define PMCRB_MAIN_RESTART_BIT 1
`define PMCRB_MAIN_POL_LSB 2
`define PMCRB_MAIN_SEL_LSB 5
`define PMCRB_MAIN_RSVD_BIT 7
`define PMCRB_LP_LOCK_EXIT_BIT 6
`define PMCRB_LP_TURN_OFF_BIT 7
`define PMCRB_WDT_EN_BIT 0
`define PMCRB_WDT_RELOAD_BIT 1
`define PMCRB_WDT_SEL_LSB 2
`define PMCRB_MODE_STATE_BIT 4

`define PMCRB_LOW_SUPPLY_MASK 8'h3f
`define PMCRB_LONG_PRESS_MASK 8'hcf
`define PMCRB_WDT_CTRL_MASK 8'h0d
`define PMCRB_DISCH_2_MASK 8'h3f

`define PMCRB_SECOND_NS 1000000000
`define PMCRB_CLK_PERIOD_NS 100

`endif

/* File: verilog/pmcrb_pkg.sv */
// Purpose: types shared by the control register bank
// Assumes: nothing beyond the defs header
// Notes: no constants here, they live in pmcrb_defs.svh
package pmcrb_pkg;

  // defaults that come from non-volatile configuration
  typedef struct packed {
    logic lp_turn_off;
    logic lp_lock_exit;
    logic [3:0] lp_duration;
    logic wdt_enable;
    logic [7:0] wdt_period;
    logic [7:0] ocp_switchers;
    logic [7:0] ocp_linears;
    logic [7:0] disch_1;
    logic [5:0] disch_2;
  } pmcrb_nvm_t;

  // settings handed to the analog and pad logic
  typedef struct packed {
    logic low_supply_monitor_enable;
    logic [2:0] low_supply_rise_threshold;
    logic [1:0] low_supply_hysteresis;
    logic [7:0] ocp_switchers;
    logic [7:0] ocp_linears;
    logic [5:0] ctrl_pin_pull_select;
    logic wake_pin_pullup;
    logic key_pin_pullup;
    logic [13:0] buck_discharge_select;
  } pmcrb_cfg_t;

  // register-side port of the serial bus slave
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } pmcrb_req_t;

endpackage : pmcrb_pkg

/* File: verilog/pmcrb_regbank.sv */
// Purpose: control register bank: switch-off, standby select, watchdog, long press, pads
// Assumes: register requests arrive from the serial slave on sys_clk_i; pins are asynchronous
// Notes: load strobes come from the power state machine outside this block
// How it works
// - main control resets 0x80, reloads on check
// - standby source selects control input, supplies-up only
// - per-input polarity bit sets active level
// - writing one to switch-off requests shutdown
// - restart bit picks power cycle over off
// - low-supply register resets zero, bit0 enables
// - rise threshold code at bits 3:1
// - hysteresis code at bits 5:4
// - long press lasts code plus one seconds
// - turn-off bit makes long press a turn-off
// - lock-exit bit frees lockout on long press
// - watchdog enable bit, default from nvm
// - watchdog suspended while selected input active
// - reload bit reloads counter, reads zero
// - period setting gives value plus one seconds
// - remaining count read-only, resets zero
// - per-regulator overcurrent level bits, two registers
// - pad pull register resets 0x57, field codes
// - two-bit discharge select per switching regulator
// - discharge registers reload on init and check
// - nvm fields reload from nvm on load
// - mode status bit four shows standby state
`timescale 1ns/1ps
`default_nettype none
`include "pmcrb_defs.svh"

module pmcrb_regbank #(
  parameter int unsigned TICK_CYCLES = `PMCRB_SECOND_NS / `PMCRB_CLK_PERIOD_NS
) (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire pmcrb_pkg::pmcrb_req_t reg_req_i,
  output logic [7:0] reg_rdata_o,
  input wire logic [2:0] ctrl_pin_i,
  input wire logic power_key_n_i,
  input wire pmcrb_pkg::pmcrb_nvm_t nvm_i,
  input wire logic init_load_i,
  input wire logic check_load_i,
  input wire logic supplies_up_i,
  input wire logic fault_lockout_i,
  output logic software_switch_off_req_o,
  output logic software_switch_off_restart_o,
  output logic standby_o,
  output logic long_press_off_o,
  output logic lock_exit_o,
  output logic wdt_fault_o,
  output pmcrb_pkg::pmcrb_cfg_t cfg_o
);

  // pin synchronisers: stage one read only by stage two
  logic [3:0] pin_meta_q;
  logic [3:0] pin_sync_q;

  always_ff @(posedge sys_clk_i) begin
    pin_meta_q <= {power_key_n_i, ctrl_pin_i};
    pin_sync_q <= pin_meta_q;
  end

  // register storage
  logic [7:0] main_q;
  logic [7:0] main_d;
  logic [7:0] lsm_q;
  logic [7:0] lsm_d;
  logic [7:0] lp_q;
  logic [7:0] lp_d;
  logic [7:0] wctl_q;
  logic [7:0] wctl_d;
  logic [7:0] wper_q;
  logic [7:0] wper_d;
  logic [7:0] ocp_sw_q;
  logic [7:0] ocp_sw_d;
  logic [7:0] ocp_ldo_q;
  logic [7:0] ocp_ldo_d;
  logic [7:0] pull_q;
  logic [7:0] pull_d;
  logic [7:0] dis1_q;
  logic [7:0] dis1_d;
  logic [7:0] dis2_q;
  logic [7:0] dis2_d;

  // load strobes
  wire load_all = sys_rst_i | check_load_i;
  wire load_disch = load_all | init_load_i;

  // address decode
  wire wr = reg_req_i.wr;
  wire [7:0] wdata = reg_req_i.wdata;
  wire wr_main = wr && (reg_req_i.addr == `PMCRB_ADDR_MAIN_CTRL);
  wire wr_lsm = wr && (reg_req_i.addr == `PMCRB_ADDR_LOW_SUPPLY);
  wire wr_lp = wr && (reg_req_i.addr == `PMCRB_ADDR_LONG_PRESS);
  wire wr_wctl = wr && (reg_req_i.addr == `PMCRB_ADDR_WDT_CTRL);
  wire wr_wper = wr && (reg_req_i.addr == `PMCRB_ADDR_WDT_PERIOD);
  wire wr_ocp_sw = wr && (reg_req_i.addr == `PMCRB_ADDR_OCP_SW);
  wire wr_ocp_ldo = wr && (reg_req_i.addr == `PMCRB_ADDR_OCP_LDO);
  wire wr_pull = wr && (reg_req_i.addr == `PMCRB_ADDR_PAD_PULL);
  wire wr_dis1 = wr && (reg_req_i.addr == `PMCRB_ADDR_DISCH_1);
  wire wr_dis2 = wr && (reg_req_i.addr == `PMCRB_ADDR_DISCH_2);

  // switch-off bit is a strobe and never stored; bit seven kept as software wrote it
  wire [7:0] main_wr_val = wdata & ~(8'h01 << `PMCRB_MAIN_SOFTWARE_SWITCH_OFF_BIT);
  // reload bit is a strobe and never stored
  wire [7:0] wctl_wr_val = wdata & `PMCRB_WDT_CTRL_MASK;
  wire [7:0] lp_nvm = {nvm_i.lp_turn_off, nvm_i.lp_lock_exit, 2'b00, nvm_i.lp_duration};
  wire [7:0] wctl_nvm = {7'h00, nvm_i.wdt_enable};

  // next values: a load wins over a write in the same cycle
  assign main_d = load_all ? `PMCRB_RST_MAIN_CTRL : (wr_main ? main_wr_val : main_q);
  assign lsm_d = load_all ? `PMCRB_RST_LOW_SUPPLY :
                 (wr_lsm ? (wdata & `PMCRB_LOW_SUPPLY_MASK) : lsm_q);
  assign lp_d = load_all ? lp_nvm : (wr_lp ? (wdata & `PMCRB_LONG_PRESS_MASK) : lp_q);
  assign wctl_d = load_all ? wctl_nvm : (wr_wctl ? wctl_wr_val : wctl_q);
  assign wper_d = load_all ? nvm_i.wdt_period : (wr_wper ? wdata : wper_q);
  assign ocp_sw_d = load_all ? nvm_i.ocp_switchers : (wr_ocp_sw ? wdata : ocp_sw_q);
  assign ocp_ldo_d = load_all ? nvm_i.ocp_linears : (wr_ocp_ldo ? wdata : ocp_ldo_q);
  assign pull_d = load_all ? `PMCRB_RST_PAD_PULL : (wr_pull ? wdata : pull_q);
  assign dis1_d = load_disch ? nvm_i.disch_1 : (wr_dis1 ? wdata : dis1_q);
  assign dis2_d = load_disch ? {2'b00, nvm_i.disch_2} :
                  (wr_dis2 ? (wdata & `PMCRB_DISCH_2_MASK) : dis2_q);

  always_ff @(posedge sys_clk_i) begin
    main_q <= main_d;
    lsm_q <= lsm_d;
    lp_q <= lp_d;
    wctl_q <= wctl_d;
    wper_q <= wper_d;
    ocp_sw_q <= ocp_sw_d;
    ocp_ldo_q <= ocp_ldo_d;
    pull_q <= pull_d;
    dis1_q <= dis1_d;
    dis2_q <= dis2_d;
  end

  // active state of each control input under its polarity bit
  logic [2:0] ctrl_active;
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_pol
      // polarity one means active high, zero active low
      assign ctrl_active[gi] =
        ~(pin_sync_q[gi] ^ main_q[`PMCRB_MAIN_POL_LSB + gi]);
    end
  endgenerate

  // source selection: code zero selects nothing, one to three pick an input
  wire [1:0] stby_sel = main_q[`PMCRB_MAIN_SEL_LSB +: 2];
  wire [1:0] wdt_sel = wctl_q[`PMCRB_WDT_SEL_LSB +: 2];
  wire stby_active = (stby_sel != 2'h0) && ctrl_active[stby_sel - 2'h1];
  wire wdt_suspend = (wdt_sel != 2'h0) && ctrl_active[wdt_sel - 2'h1];
  wire standby_d = supplies_up_i && stby_active;

  // one-second tick shared by the watchdog
  logic [31:0] tick_cnt_q;
  logic [31:0] tick_cnt_d;
  wire tick = (tick_cnt_q == TICK_CYCLES - 1);
  assign tick_cnt_d = (sys_rst_i || tick) ? 32'h0 : tick_cnt_q + 32'h1;

  // watchdog down-counter: value n means n+1 seconds remain
  logic [7:0] wdt_cnt_q;
  logic [7:0] wdt_cnt_d;
  wire wdt_reload = wr_wctl && wdata[`PMCRB_WDT_RELOAD_BIT];
  wire wdt_run = wctl_q[`PMCRB_WDT_EN_BIT] && !wdt_suspend;
  wire wdt_expire = wdt_run && tick && (wdt_cnt_q == 8'h00);

  always_comb begin
    wdt_cnt_d = wdt_cnt_q;
    if (load_all) begin
      wdt_cnt_d = `PMCRB_RST_WDT_REMAIN;
    end else if (wdt_reload || wdt_expire) begin
      wdt_cnt_d = wper_q;
    end else if (wdt_run && tick) begin
      wdt_cnt_d = wdt_cnt_q - 8'h01;
    end
  end

  // long press: seconds of continuous key activity, restarted on release
  logic [31:0] lp_pre_q;
  logic [31:0] lp_pre_d;
  logic [3:0] lp_sec_q;
  logic [3:0] lp_sec_d;
  logic lp_done_q;
  logic lp_done_d;
  wire key_active = ~pin_sync_q[3];
  wire lp_sec_tick = (lp_pre_q == TICK_CYCLES - 1);
  wire lp_hit = key_active && !lp_done_q && lp_sec_tick &&
                (lp_sec_q == lp_q[3:0]);

  always_comb begin
    lp_pre_d = lp_pre_q + 32'h1;
    lp_sec_d = lp_sec_q;
    lp_done_d = lp_done_q | lp_hit;
    if (sys_rst_i || !key_active) begin
      lp_pre_d = 32'h0;
      lp_sec_d = 4'h0;
      lp_done_d = 1'b0;
    end else if (lp_done_q) begin
      lp_pre_d = 32'h0;
    end else if (lp_sec_tick) begin
      lp_pre_d = 32'h0;
      lp_sec_d = lp_sec_q + 4'h1;
    end
  end

  // read mux
  logic [7:0] rd_val;
  always_comb begin
    unique case (reg_req_i.addr)
      `PMCRB_ADDR_MODE_STATUS: rd_val = {3'b000, standby_o, 1'b0, ~ctrl_active};
      `PMCRB_ADDR_MAIN_CTRL: rd_val = main_q;
      `PMCRB_ADDR_LOW_SUPPLY: rd_val = lsm_q;
      `PMCRB_ADDR_LONG_PRESS: rd_val = lp_q;
      `PMCRB_ADDR_WDT_CTRL: rd_val = wctl_q;
      `PMCRB_ADDR_WDT_PERIOD: rd_val = wper_q;
      `PMCRB_ADDR_WDT_REMAIN: rd_val = wdt_cnt_q;
      `PMCRB_ADDR_OCP_SW: rd_val = ocp_sw_q;
      `PMCRB_ADDR_OCP_LDO: rd_val = ocp_ldo_q;
      `PMCRB_ADDR_PAD_PULL: rd_val = pull_q;
      `PMCRB_ADDR_DISCH_1: rd_val = dis1_q;
      `PMCRB_ADDR_DISCH_2: rd_val = dis2_q;
      default: rd_val = 8'h00;
    endcase
  end

  // event pulses
  wire software_switch_off_d = wr_main && wdata[`PMCRB_MAIN_SOFTWARE_SWITCH_OFF_BIT] && !load_all;
  wire lp_off_d = lp_hit && lp_q[`PMCRB_LP_TURN_OFF_BIT];
  wire lock_exit_d = lp_hit && lp_q[`PMCRB_LP_LOCK_EXIT_BIT] && fault_lockout_i;

  always_ff @(posedge sys_clk_i) begin
    tick_cnt_q <= tick_cnt_d;
    wdt_cnt_q <= wdt_cnt_d;
    lp_pre_q <= lp_pre_d;
    lp_sec_q <= lp_sec_d;
    lp_done_q <= lp_done_d;
    if (sys_rst_i) begin
      reg_rdata_o <= 8'h00;
      software_switch_off_req_o <= 1'b0;
      software_switch_off_restart_o <= 1'b0;
      standby_o <= 1'b0;
      long_press_off_o <= 1'b0;
      lock_exit_o <= 1'b0;
      wdt_fault_o <= 1'b0;
    end else begin
      if (reg_req_i.rd) begin
        reg_rdata_o <= rd_val;
      end
      software_switch_off_req_o <= software_switch_off_d;
      // restart choice sampled with the switch-off strobe
      software_switch_off_restart_o <= software_switch_off_d && wdata[`PMCRB_MAIN_RESTART_BIT];
      standby_o <= standby_d;
      long_press_off_o <= lp_off_d;
      lock_exit_o <= lock_exit_d;
      wdt_fault_o <= wdt_expire;
    end
  end

  // configuration out, straight from register flops
  assign cfg_o.low_supply_monitor_enable = lsm_q[0];
  assign cfg_o.low_supply_rise_threshold = lsm_q[3:1];
  assign cfg_o.low_supply_hysteresis = lsm_q[5:4];
  assign cfg_o.ocp_switchers = ocp_sw_q;
  assign cfg_o.ocp_linears = ocp_ldo_q;
  assign cfg_o.ctrl_pin_pull_select = pull_q[7:2];
  assign cfg_o.wake_pin_pullup = pull_q[1];
  assign cfg_o.key_pin_pullup = pull_q[0];
  assign cfg_o.buck_discharge_select = {dis2_q[5:0], dis1_q};

endmodule // pmcrb_regbank

`default_nettype wire

/* File: dv/pmcrb_regbank_sva.sv */
// Purpose: port-level timing checks for the control register bank
// Assumes: one clock domain, synchronous active-high reset
// Notes: bound to every pmcrb_regbank instance
`timescale 1ns/1ps
`default_nettype none
module pmcrb_regbank_sva (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire pmcrb_pkg::pmcrb_req_t reg_req_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic check_load_i,
  input wire logic supplies_up_i,
  input wire logic fault_lockout_i,
  input wire logic software_switch_off_req_o,
  input wire logic software_switch_off_restart_o,
  input wire logic standby_o,
  input wire logic long_press_off_o,
  input wire logic lock_exit_o,
  input wire logic wdt_fault_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);
  chk_software_switch_off_raise:
    assert property (reg_req_i.wr && reg_req_i.addr == 8'h10 && reg_req_i.wdata[0] &&
      !check_load_i |=> software_switch_off_req_o) else $error("switch-off write gave no request");
  chk_software_switch_off_cause:
    assert property (software_switch_off_req_o |-> $past(reg_req_i.wr) && $past(reg_req_i.wdata[0]) &&
      $past(reg_req_i.addr) == 8'h10) else $error("switch-off request without a write");
  chk_restart_pair:
    assert property (software_switch_off_restart_o |-> software_switch_off_req_o && $past(reg_req_i.wdata[1]))
      else $error("restart request not paired with switch-off");
  chk_standby_supplies:
    assert property (standby_o |-> $past(supplies_up_i)) else $error("standby outside supplies up");
  chk_lock_exit:
    assert property (lock_exit_o |-> $past(fault_lockout_i)) else $error("lock exit outside lockout");
  chk_fault_pulse:
    assert property ($rose(wdt_fault_o) |=> !wdt_fault_o) else $error("watchdog fault not a pulse");
  chk_main_readback:
    assert property (reg_req_i.rd && reg_req_i.addr == 8'h10 |=> !reg_rdata_o[0])
      else $error("switch-off bit reads back one");
  chk_wdt_readback:
    assert property (reg_req_i.rd && reg_req_i.addr == 8'h13 |=>
      reg_rdata_o[7:4] == 4'h0 && !reg_rdata_o[1]) else $error("watchdog control readback");
  chk_low_readback:
    assert property (reg_req_i.rd && reg_req_i.addr == 8'h11 |=> reg_rdata_o[7:6] == 2'h0)
      else $error("low-supply reserved bits read nonzero");
  chk_load_no_software_switch_off:
    assert property (check_load_i |=> !software_switch_off_req_o)
      else $error("switch-off request beside a register load");
  chk_press_pulse:
    assert property ($rose(long_press_off_o) |=> !long_press_off_o)
      else $error("long press turn-off not a single pulse");
endmodule // pmcrb_regbank_sva
bind pmcrb_regbank pmcrb_regbank_sva pmcrb_regbank_sva_i (.sys_clk_i, .sys_rst_i, .reg_req_i,
  .reg_rdata_o, .check_load_i, .supplies_up_i, .fault_lockout_i, .software_switch_off_req_o,
  .software_switch_off_restart_o, .standby_o, .long_press_off_o, .lock_exit_o, .wdt_fault_o);
`default_nettype wire

/* File: dv/pmcrb_host.sv */
// Purpose: host model driving register requests and control pins
// Assumes: requests change just after a rising edge
// Notes: released address and data show inverted values
`timescale 1ns/1ps
`default_nettype none
module pmcrb_host (
  input wire logic sys_clk_i,
  input wire logic [7:0] reg_rdata_i,
  output var pmcrb_pkg::pmcrb_req_t reg_req_o,
  output logic [2:0] ctrl_pin_o,
  output logic power_key_n_o
);
  initial begin
    reg_req_o = '0;
    ctrl_pin_o = 3'h0;
    power_key_n_o = 1'b1;
  end
  task automatic write(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    reg_req_o <= {1'b1, 1'b0, a, (a == 8'h10) ? (d | 8'h80) : d};
    @(posedge sys_clk_i);
    reg_req_o <= {1'b0, 1'b0, ~a, ~d};
  endtask
  task automatic read(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk_i);
    reg_req_o <= {1'b0, 1'b1, a, ~reg_req_o.wdata};
    @(posedge sys_clk_i);
    reg_req_o <= {1'b0, 1'b0, ~a, reg_req_o.wdata};
    #1 d = reg_rdata_i;
  endtask
  task automatic pins(input logic [2:0] c, input logic k);
    @(posedge sys_clk_i);
    ctrl_pin_o <= c;
    power_key_n_o <= k;
  endtask
endmodule // pmcrb_host
`default_nettype wire

/* File: dv/pmcrb_regbank_test.sv */
// Purpose: self-checking bench for the control register bank
// Assumes: one second shortened to 10 clock cycles
// Notes: nvm defaults fixed below
`timescale 1ns/1ps
`default_nettype none
module pmcrb_regbank_test;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic init_load = 1'b0;
  logic check_load = 1'b0;
  logic supplies_up = 1'b1;
  logic lockout = 1'b0;
  pmcrb_pkg::pmcrb_nvm_t nvm = {1'b0, 1'b1, 4'h3, 1'b0, 8'h05, 8'h3c, 8'hc3, 8'h96, 6'h2d};
  pmcrb_pkg::pmcrb_req_t req;
  pmcrb_pkg::pmcrb_cfg_t cfg;
  logic [7:0] rdata;
  logic [2:0] pin;
  logic key_n, software_switch_off, restart, standby, lp_off, lock_exit, wdt_fault;
  int error_cnt = 0;
  int n_checks = 0;
  int cycles = 0;
  int n;
  always #50 clk = ~clk;
  pmcrb_host pmcrb_host_i (.sys_clk_i(clk), .reg_rdata_i(rdata), .reg_req_o(req),
    .ctrl_pin_o(pin), .power_key_n_o(key_n));
  pmcrb_regbank #(.TICK_CYCLES(10)) pmcrb_regbank_i (.sys_clk_i(clk), .sys_rst_i(rst),
    .reg_req_i(req), .reg_rdata_o(rdata), .ctrl_pin_i(pin), .power_key_n_i(key_n),
    .nvm_i(nvm), .init_load_i(init_load), .check_load_i(check_load),
    .supplies_up_i(supplies_up), .fault_lockout_i(lockout), .software_switch_off_req_o(software_switch_off),
    .software_switch_off_restart_o(restart), .standby_o(standby), .long_press_off_o(lp_off),
    .lock_exit_o(lock_exit), .wdt_fault_o(wdt_fault), .cfg_o(cfg));
  task automatic complete_run();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      error_cnt++;
      complete_run();
    end
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] v;
    pmcrb_host_i.read(a, v);
    chk(v, exp);
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  // counts edges until the chosen pulse shows, k 0 watchdog, 1 long press
  task automatic watch(input int k, input int lim);
    n = 0;
    while ((k == 0 ? wdt_fault : lp_off) !== 1'b1 && n < lim) begin
      cyc(1);
      n++;
    end
  endtask
  task automatic t_defaults();
    rc(8'h10, 8'h80);
    rc(8'h11, 8'h00);
    rc(8'h12, 8'h43);
    rc(8'h14, 8'h05);
    rc(8'h15, 8'h00);
    rc(8'h16, 8'h3c);
    rc(8'h18, 8'h57);
  endtask
  task automatic t_software_switch_off();
    pmcrb_host_i.write(8'h10, 8'h01);
    #1 chk({6'h0, restart, software_switch_off}, 8'h01);
    pmcrb_host_i.write(8'h10, 8'h03);
    #1 chk({6'h0, restart, software_switch_off}, 8'h03);
    pmcrb_host_i.write(8'h10, 8'h00);
    #1 chk({6'h0, restart, software_switch_off}, 8'h00);
  endtask
  task automatic t_standby();
    pmcrb_host_i.pins(3'h1, 1'b1);
    for (int s = 1; s < 4; s++) begin
      pmcrb_host_i.write(8'h10, {1'b1, 2'(s), 5'h04});
      cyc(4);
      chk({7'h0, standby}, 8'h01);
    end
    rc(8'h0c, 8'h10);
    pmcrb_host_i.write(8'h10, 8'ha0);
    cyc(4);
    chk({7'h0, standby}, 8'h00);
    rc(8'h0c, 8'h01);
    pmcrb_host_i.write(8'h10, 8'he0);
    supplies_up <= 1'b0;
    cyc(4);
    chk({7'h0, standby}, 8'h00);
    supplies_up <= 1'b1;
  endtask
  task automatic t_low();
    pmcrb_host_i.write(8'h11, 8'hff);
    rc(8'h11, 8'h3f);
    pmcrb_host_i.write(8'h11, 8'h2b);
    // settings land on the write edge, so look just after it
    #1 chk({2'h0, cfg.low_supply_hysteresis, cfg.low_supply_rise_threshold,
      cfg.low_supply_monitor_enable}, 8'h2b);
  endtask
  task automatic t_wdt();
    pmcrb_host_i.write(8'h14, 8'h01);
    pmcrb_host_i.write(8'h13, 8'h03);
    rc(8'h13, 8'h01);
    watch(0, 40);
    chk(8'(n > 6 && n < 24), 8'h01);
    cyc(1);
    watch(0, 40);
    chk(8'(n), 8'h13);
    pmcrb_host_i.write(8'h10, 8'h84);
    pmcrb_host_i.write(8'h13, 8'h07);
    watch(0, 60);
    chk(8'(n), 8'h3c);
    rc(8'h15, 8'h01);
    pmcrb_host_i.pins(3'h0, 1'b1);
    watch(0, 40);
    chk(8'(n < 30), 8'h01);
    pmcrb_host_i.write(8'h13, 8'h00);
    watch(0, 40);
    chk(8'(n), 8'h28);
    // remaining count is read-only: a write must leave it alone
    pmcrb_host_i.write(8'h15, 8'hff);
    rc(8'h15, 8'h01);
  endtask
  task automatic t_press();
    lockout <= 1'b1;
    pmcrb_host_i.write(8'h12, 8'hc1);
    pmcrb_host_i.pins(3'h0, 1'b0);
    cyc(12);
    pmcrb_host_i.pins(3'h0, 1'b1);
    pmcrb_host_i.pins(3'h0, 1'b0);
    watch(1, 40);
    chk({6'h0, lock_exit, lp_off}, 8'h03);
    chk(8'(n > 19 && n < 25), 8'h01);
    pmcrb_host_i.pins(3'h0, 1'b1);
    pmcrb_host_i.write(8'h12, 8'h01);
    pmcrb_host_i.pins(3'h0, 1'b0);
    watch(1, 40);
    chk(8'(n), 8'h28);
    pmcrb_host_i.pins(3'h0, 1'b1);
    lockout <= 1'b0;
  endtask
  task automatic t_load();
    pmcrb_host_i.write(8'h18, 8'h00);
    pmcrb_host_i.write(8'h19, 8'h0f);
    pmcrb_host_i.write(8'h1a, 8'hff);
    pmcrb_host_i.write(8'h17, 8'h5a);
    rc(8'h1a, 8'h3f);
    rc(8'h17, 8'h5a);
    @(posedge clk) init_load <= 1'b1;
    @(posedge clk) init_load <= 1'b0;
    rc(8'h19, 8'h96);
    rc(8'h1a, 8'h2d);
    rc(8'h18, 8'h00);
    @(posedge clk) check_load <= 1'b1;
    @(posedge clk) check_load <= 1'b0;
    rc(8'h10, 8'h80);
    rc(8'h18, 8'h57);
    rc(8'h17, 8'hc3);
    rc(8'h1a, 8'h2d);
    chk(cfg.ocp_switchers, 8'h3c);
    chk(cfg.ocp_linears, 8'hc3);
    chk({cfg.ctrl_pin_pull_select, cfg.wake_pin_pullup,
      cfg.key_pin_pullup}, 8'h57);
    chk(cfg.buck_discharge_select[7:0], 8'h96);
    chk({2'h0, cfg.buck_discharge_select[13:8]}, 8'h2d);
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_defaults();
    t_software_switch_off();
    t_standby();
    t_low();
    t_wdt();
    t_press();
    t_load();
    complete_run();
  end
endmodule // pmcrb_regbank_test
`default_nettype wire
